// file: ewp_regs.svh
// Timing counts and command constants for the EEPROM write controller.
`ifndef EWP_REGS_SVH
`define EWP_REGS_SVH
`define EWP_CLK_NS 20
`define EWP_STROBE_NS 200
`define EWP_STROBE_CYC ((`EWP_STROBE_NS + `EWP_CLK_NS - 1) / `EWP_CLK_NS)
`define EWP_GAP_NS 300
`define EWP_GAP_CYC ((`EWP_GAP_NS + `EWP_CLK_NS - 1) / `EWP_CLK_NS)
`define EWP_BLC_MAX_NS 30000
`define EWP_BLC_MAX_CYC (`EWP_BLC_MAX_NS / `EWP_CLK_NS)
`define EWP_PROG_MS 10
`define EWP_PROG_CYC (`EWP_PROG_MS * 1000000 / `EWP_CLK_NS)
`define EWP_ADDR_A 15'h5555
`define EWP_ADDR_B 15'h2AAA
`define EWP_DAT_AA 8'hAA
`define EWP_DAT_55 8'h55
`define EWP_DAT_A0 8'hA0
`define EWP_DAT_80 8'h80
`define EWP_DAT_20 8'h20
`endif

// file: ewp_pkg.sv
// Types for the EEPROM write controller.
package ewp_pkg;
  typedef struct packed {
    logic [14:0] addr;
    logic [7:0] data;
  } ewp_word_t;

  typedef enum logic [3:0] {
    EWP_OP_WRITE = 4'h1,
    EWP_OP_LOCK_ON = 4'h2,
    EWP_OP_LOCK_OFF = 4'h4
  } ewp_op_t;

  typedef enum logic [5:0] {
    EWP_IDLE = 6'h01,
    EWP_LOAD = 6'h02,
    EWP_STRB = 6'h04,
    EWP_GAP = 6'h08,
    EWP_PROG = 6'h10,
    EWP_DONE = 6'h20
  } ewp_state_t;

  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic hold_off_n;
    logic [14:0] addr;
    logic [7:0] dout;
    logic dq_oe_n;
  } ewp_pins_t;

  typedef struct packed {
    ewp_state_t state;
    ewp_pins_t pins;
    ewp_op_t op;
    ewp_word_t word;
    logic [2:0] step;
    logic [2:0] nsteps;
    logic [31:0] cnt;
    logic busy;
    logic done;
  } ewp_st_t;
endpackage : ewp_pkg

// file: ewp_ctrl.sv
// Host-side write controller driving a byte-wide EEPROM through its pins.
`timescale 1ns/1ps
`include "ewp_regs.svh"
module ewp_ctrl #(
  parameter int PROG_CYC = `EWP_PROG_CYC,
  parameter int BLC_MAX_CYC = `EWP_BLC_MAX_CYC
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic req,
  input wire ewp_pkg::ewp_op_t req_op,
  input wire ewp_pkg::ewp_word_t req_word,
  input wire logic lock_on,
  input wire logic hold_req,
  output logic busy,
  output logic done,
  output logic ce_n,
  output logic oe_n,
  output logic we_n,
  output logic hold_off_n,
  output logic [14:0] addr,
  output logic [7:0] dout,
  output logic dq_oe_n
);
  localparam logic [31:0] STRB = 32'(`EWP_STROBE_CYC);
  localparam logic [31:0] GAP = 32'(`EWP_GAP_CYC);

  ewp_pkg::ewp_st_t st;
  ewp_pkg::ewp_st_t next_st;

  // Word presented at a given step of the current sequence.
  function automatic ewp_pkg::ewp_word_t seq_word(
    input ewp_pkg::ewp_op_t op, input logic [2:0] step,
    input ewp_pkg::ewp_word_t user);
    ewp_pkg::ewp_word_t w;
    w = user;
    case (op)
      ewp_pkg::EWP_OP_LOCK_OFF:
        case (step)
          3'h0, 3'h3: w = '{`EWP_ADDR_A, `EWP_DAT_AA};
          3'h1, 3'h4: w = '{`EWP_ADDR_B, `EWP_DAT_55};
          3'h2: w = '{`EWP_ADDR_A, `EWP_DAT_80};
          default: w = '{`EWP_ADDR_A, `EWP_DAT_20};
        endcase
      default:
        case (step)
          3'h0: w = '{`EWP_ADDR_A, `EWP_DAT_AA};
          3'h1: w = '{`EWP_ADDR_B, `EWP_DAT_55};
          3'h2: w = '{`EWP_ADDR_A, `EWP_DAT_A0};
          default: w = user;
        endcase
    endcase
    return w;
  endfunction : seq_word

  always_comb
  begin
    next_st = st;
    next_st.done = 1'b0;
    case (st.state)
      ewp_pkg::EWP_IDLE:
      begin
        // Hold-off follows the host's request only between operations,
        // so a late request can never cut off bytes already loaded.
        next_st.pins.hold_off_n = ~hold_req;
        next_st.pins.ce_n = 1'b1;
        next_st.pins.we_n = 1'b1;
        next_st.pins.oe_n = 1'b1;
        next_st.pins.dq_oe_n = 1'b1;
        if (req && !hold_req)
        begin
          next_st.op = req_op;
          next_st.word = req_word;
          next_st.step = 3'h0;
          // Plain writes skip the prefix only while the lock is off.
          if (req_op == ewp_pkg::EWP_OP_LOCK_OFF)
            next_st.nsteps = 3'h6;
          else if (req_op == ewp_pkg::EWP_OP_LOCK_ON || lock_on)
            next_st.nsteps = 3'h4;
          else
            next_st.nsteps = 3'h1;
          if (req_op == ewp_pkg::EWP_OP_WRITE && !lock_on)
            next_st.step = 3'h3;
          next_st.busy = 1'b1;
          next_st.state = ewp_pkg::EWP_LOAD;
        end
      end
      ewp_pkg::EWP_LOAD:
      begin
        // Address and data change on the same clock edge as the strobe falls.
        {next_st.pins.addr, next_st.pins.dout} =
          seq_word(st.op, st.step, st.word);
        next_st.pins.dq_oe_n = 1'b0;
        next_st.pins.oe_n = 1'b1;
        next_st.pins.ce_n = 1'b0;
        next_st.pins.we_n = 1'b0;
        next_st.cnt = 32'h0;
        next_st.state = ewp_pkg::EWP_STRB;
      end
      ewp_pkg::EWP_STRB:
      begin
        next_st.cnt = st.cnt + 32'h1;
        if (st.cnt + 32'h1 >= STRB)
        begin
          next_st.pins.we_n = 1'b1;
          next_st.pins.ce_n = 1'b1;
          next_st.cnt = 32'h0;
          next_st.state = ewp_pkg::EWP_GAP;
        end
      end
      ewp_pkg::EWP_GAP:
      begin
        next_st.cnt = st.cnt + 32'h1;
        if (st.cnt + 32'h1 >= GAP)
        begin
          next_st.pins.dq_oe_n = 1'b1;
          next_st.cnt = 32'h0;
          // The count of bytes left decides whether programming follows.
          if (st.nsteps == 3'h1)
            next_st.state = ewp_pkg::EWP_PROG;
          else
          begin
            next_st.step = st.step + 3'h1;
            next_st.nsteps = st.nsteps - 3'h1;
            next_st.state = ewp_pkg::EWP_LOAD;
          end
        end
      end
      ewp_pkg::EWP_PROG:
      begin
        // Hold-off stays high until programming has surely ended.
        next_st.pins.hold_off_n = 1'b1;
        next_st.cnt = st.cnt + 32'h1;
        if (st.cnt + 32'h1 >= 32'(PROG_CYC))
          next_st.state = ewp_pkg::EWP_DONE;
      end
      default:
      begin
        next_st.pins.hold_off_n = ~hold_req;
        next_st.busy = 1'b0;
        next_st.done = 1'b1;
        next_st.cnt = 32'h0;
        next_st.state = ewp_pkg::EWP_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st <= '0;
      st.state <= ewp_pkg::EWP_IDLE;
      st.op <= ewp_pkg::EWP_OP_WRITE;
      st.pins <= '{1'b1, 1'b1, 1'b1, 1'b0, 15'h0000, 8'h00, 1'b1};
    end
    else
      st <= next_st;
  end

  assign busy = st.busy;
  assign done = st.done;
  assign ce_n = st.pins.ce_n;
  assign oe_n = st.pins.oe_n;
  assign we_n = st.pins.we_n;
  assign hold_off_n = st.pins.hold_off_n;
  assign addr = st.pins.addr;
  assign dout = st.pins.dout;
  assign dq_oe_n = st.pins.dq_oe_n;

  default clocking ewp_cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);

  // Each low strobe lasts the full pulse width, far above the filter.
  sequence s_we_fall;
    $fell(we_n);
  endsequence
  sequence s_we_low_long;
    !we_n [*8];
  endsequence
  chk_strobe_width: assert property (s_we_fall |-> s_we_low_long)
    else $error("write strobe shorter than pulse width");
  chk_addr_stable: assert property (
    !we_n && !$fell(we_n) |-> $stable(addr) && $stable(dout))
    else $error("address or data moved while strobe low");
  chk_idle_safe: assert property (!busy |-> ce_n && we_n)
    else $error("idle controller left strobes active");
  chk_oe_high: assert property (!we_n |-> oe_n && !ce_n && !dq_oe_n)
    else $error("output drive active during write strobe");
  chk_hold_prog: assert property (busy |-> hold_off_n)
    else $error("hold-off dropped during an operation");
  chk_next_load: assert property (
    $rose(we_n) && st.state == ewp_pkg::EWP_GAP |->
    ##[1:40] (!we_n || st.state == ewp_pkg::EWP_PROG))
    else $error("next byte load too late");
  chk_gap_limit: assert property (
    st.state == ewp_pkg::EWP_GAP |-> st.cnt < 32'(BLC_MAX_CYC))
    else $error("byte load gap exceeds load window");
  chk_prefix: assert property (
    st.state == ewp_pkg::EWP_LOAD && st.step == 3'h0 |=>
    addr == `EWP_ADDR_A && dout == `EWP_DAT_AA)
    else $error("sequence does not start with command prefix");
  chk_disable_end: assert property (
    st.state == ewp_pkg::EWP_LOAD && st.step == 3'h5 |=>
    dout == `EWP_DAT_20)
    else $error("disable sequence ends with wrong byte");
  chk_hold_req: assert property (hold_req && !busy |=> !hold_off_n)
    else $error("hold-off not driven low on request");
endmodule : ewp_ctrl

// file: ewp_dev_model.sv
// Behavioural model of the byte-wide EEPROM write and protection logic.
`timescale 1ns/1ps
module ewp_dev_model #(
  parameter int PROG_NS = 1000
) (
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic hold_off_n,
  input wire logic [14:0] addr,
  input wire logic [7:0] dout,
  input wire logic dq_oe_n
);
  localparam logic [68:0] ENA = {15'h5555, 8'hAA, 15'h2AAA, 8'h55,
    15'h5555, 8'hA0};
  localparam logic [137:0] DIS = {15'h5555, 8'hAA, 15'h2AAA, 8'h55,
    15'h5555, 8'h80, ENA[68:23], 15'h5555, 8'h20};
  logic [7:0] mem [logic [14:0]];
  logic lock = 1'b0;
  logic armed = 1'b0;
  logic [14:0] la;
  logic [14:0] pa;
  realtime t_fall;
  realtime t_prog = -1.0e9;
  logic [22:0] hist [$];
  wire strobe_n = ce_n | we_n;

  task take(input logic [22:0] w);
    hist.push_back(w);
    if (hist.size() > 6)
      void'(hist.pop_front());
    if (hist.size() == 6 && {hist[0], hist[1], hist[2], hist[3], hist[4],
        hist[5]} == DIS)
    begin
      lock = 1'b0;
      armed = 1'b0;
      hist.delete();
    end
    else if (hist.size() >= 3 && {hist[$-2], hist[$-1], hist[$]} == ENA)
      armed = 1'b1;
    else if (w[22:8] != 15'h5555 && w[22:8] != 15'h2AAA)
    begin
      if (!lock || armed)
      begin
        mem[w[22:8]] = w[7:0];
        pa = w[22:8];
        t_prog = $realtime;
        lock = lock | armed;
      end
      armed = 1'b0;
    end
  endtask : take

  // Address is caught on the strobe's fall, data on its rise.
  always @(negedge strobe_n)
  begin
    la = addr;
    t_fall = $realtime;
  end
  always @(posedge strobe_n)
    if (hold_off_n && oe_n && ($realtime - t_fall) > 20.0)
      take({la, dq_oe_n ? ~dout : dout});
  // An abort leaves the byte being programmed corrupted.
  always @(negedge hold_off_n)
    if (($realtime - t_prog) < PROG_NS)
      mem[pa] = ~mem[pa];
endmodule : ewp_dev_model

// file: tb_top.sv
// Self-checking testbench of the EEPROM write controller.
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin err_count++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb_top;
  logic sys_clk, rstn, req, lock_on, hold_req, busy, done;
  logic ce_n, oe_n, we_n, hold_off_n, dq_oe_n;
  ewp_pkg::ewp_op_t req_op;
  ewp_pkg::ewp_word_t req_word;
  logic [14:0] addr, a;
  logic [7:0] dout;
  int err_count = 0;
  int checked = 0;
  logic [15:0] lfsr = 16'h0041;
  logic exp_lock = 1'b0;
  logic [7:0] exp_mem [logic [14:0]];

  ewp_ctrl #(.PROG_CYC(50), .BLC_MAX_CYC(1500)) dut (.sys_clk(sys_clk),
    .rstn(rstn), .req(req), .req_op(req_op), .req_word(req_word),
    .lock_on(lock_on), .hold_req(hold_req), .busy(busy), .done(done),
    .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .hold_off_n(hold_off_n),
    .addr(addr), .dout(dout), .dq_oe_n(dq_oe_n));
  ewp_dev_model #(.PROG_NS(1000)) m (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
    .hold_off_n(hold_off_n), .addr(addr), .dout(dout), .dq_oe_n(dq_oe_n));

  function automatic logic [7:0] exp_at(input logic [14:0] x);
    return exp_mem.exists(x) ? exp_mem[x] : 8'hFF;
  endfunction : exp_at
  function automatic logic [7:0] dev_at(input logic [14:0] x);
    return m.mem.exists(x) ? m.mem[x] : 8'hFF;
  endfunction : dev_at
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  task finish_test;
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test

  // Runs one operation; a hold request may be raised during programming.
  task run(input ewp_pkg::ewp_op_t op, input logic lk, input logic hr);
    int n;
    lfsr = lfsr_next(lfsr);
    a = {2'b11, lfsr[12:0]};
    @(negedge sys_clk);
    req = 1'b1;
    req_op = op;
    req_word = {a, lfsr[15:8]};
    lock_on = lk;
    if (op == ewp_pkg::EWP_OP_LOCK_OFF)
      exp_lock = 1'b0;
    else if (op == ewp_pkg::EWP_OP_LOCK_ON || !exp_lock || lk)
    begin
      exp_mem[a] = lfsr[15:8];
      exp_lock = exp_lock | lk | (op == ewp_pkg::EWP_OP_LOCK_ON);
    end
    @(negedge sys_clk);
    req = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 400)
    begin
      @(negedge sys_clk);
      n++;
      if (hr && n == 40)
        hold_req = 1'b1;
    end
    `CHK("done pulse", 1'b1, done)
    `CHK("ce_n idle", 1'b1, ce_n)
    `CHK("we_n idle", 1'b1, we_n)
    `CHK("oe_n idle", 1'b1, oe_n)
    `CHK("dq_oe_n idle", 1'b1, dq_oe_n)
    `CHK("busy idle", 1'b0, busy)
    `CHK("last addr", op == ewp_pkg::EWP_OP_LOCK_OFF ? 15'h5555 : a, addr)
    `CHK("last data", op == ewp_pkg::EWP_OP_LOCK_OFF ? 8'h20 : lfsr[15:8], dout)
    `CHK("array byte", exp_at(a), dev_at(a))
    `CHK("lock state", exp_lock, m.lock)
  endtask : run

  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  initial
  begin
    #400000;
    err_count++;
    finish_test();
  end

  initial
  begin
    rstn = 1'b0;
    req = 1'b0;
    lock_on = 1'b0;
    hold_req = 1'b0;
    req_op = ewp_pkg::EWP_OP_WRITE;
    req_word = '0;
    repeat (8) @(posedge sys_clk);
    `CHK("hold_off_n in reset", 1'b0, hold_off_n)
    `CHK("ce_n in reset", 1'b1, ce_n)
    @(negedge sys_clk);
    rstn = 1'b1;
    `CHK("lock as shipped", 1'b0, m.lock)
    run(ewp_pkg::EWP_OP_WRITE, 1'b0, 1'b0);
    run(ewp_pkg::EWP_OP_LOCK_ON, 1'b0, 1'b0);
    run(ewp_pkg::EWP_OP_WRITE, 1'b0, 1'b0);
    run(ewp_pkg::EWP_OP_WRITE, 1'b1, 1'b0);
    run(ewp_pkg::EWP_OP_LOCK_OFF, 1'b0, 1'b0);
    run(ewp_pkg::EWP_OP_WRITE, 1'b0, 1'b1);
    repeat (2) @(negedge sys_clk);
    `CHK("hold_off_n held", 1'b0, hold_off_n)
    req = 1'b1;
    repeat (5) @(negedge sys_clk);
    `CHK("busy while held", 1'b0, busy)
    req = 1'b0;
    hold_req = 1'b0;
    for (int i = 0; i < 8; i++)
      run(lfsr[3] ? ewp_pkg::EWP_OP_WRITE : ewp_pkg::EWP_OP_LOCK_OFF,
        lfsr[9], 1'b0);
    finish_test();
  end
endmodule : tb_top
